// ### dhc_consts.svh
// offsets, field positions, reset values and timing counts for the dll and hold config block
`ifndef DHC_CONSTS_SVH
`define DHC_CONSTS_SVH
`define DHC_OFF_PMCR_TWO    8'h72
`define DHC_OFF_DLL_DELAY   8'h76
`define DHC_OFF_TAP_POS     8'he3
// the tap register index is not word aligned, so every register sits at four times its index
`define DHC_ADDR_PMCR_TWO   12'h1c8
`define DHC_ADDR_DLL_DELAY  12'h1d8
`define DHC_ADDR_TAP_POS    12'h38c
`define DHC_BIT_DLL_EXTEND  7
`define DHC_BIT_HOLD_HI     5
`define DHC_BIT_HOLD_LO     4
`define DHC_BIT_MAX_DELAY   2
`define DHC_RST_PMCR_TWO    8'h00
`define DHC_RST_DLL_DELAY   8'h00
`define DHC_TAP_COUNT       128
`define DHC_TAP_MAX         7'h7f
`define DHC_TAP_START       7'h40
`define DHC_LATCH_CYCLES    25
`define DHC_LOCK_HITS       4
`endif

// ### dhc_pkg.sv
// types shared by the dll and hold config block
package dhc_pkg;
  typedef enum logic [1:0] {
    DHC_MODE_NORM_NOEXT,
    DHC_MODE_NORM_EXT,
    DHC_MODE_MAX_NOEXT,
    DHC_MODE_MAX_EXT
  } dhc_dll_mode_e;
  typedef enum {DHC_ST_RESET, DHC_ST_LATCH, DHC_ST_RUN} dhc_boot_e;
  typedef logic [1:0] dhc_hold_t;
endpackage

// ### dhc_tap_tracker.sv
// dll tap pointer: steps toward phase lock over the 128 tap delay line
`timescale 1ns/100ps
`include "dhc_consts.svh"
module dhc_tap_tracker
  import dhc_pkg::*;
#(
  parameter int TAPS = `DHC_TAP_COUNT
) (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic       phase_late,
  input  wire logic       phase_early,
  output logic [6:0]      tap_q,
  output logic            locked_q
);
  logic [2:0] hits_q;

  // pointer saturates at both ends of the delay line
  always_ff @(posedge sys_clk) begin
    if (!rstn || !run) begin
      tap_q <= `DHC_TAP_START;
    end else if (phase_late && !phase_early && tap_q != 7'(TAPS - 1)) begin
      tap_q <= tap_q + 7'h01;
    end else if (phase_early && !phase_late && tap_q != 7'h00) begin
      tap_q <= tap_q - 7'h01;
    end
  end

  // lock once the comparator is balanced for several cycles in a row
  always_ff @(posedge sys_clk) begin
    if (!rstn || !run) begin
      hits_q   <= 3'h0;
      locked_q <= 1'b0;
    end else if (phase_late == phase_early) begin
      if (hits_q != 3'(`DHC_LOCK_HITS)) begin
        hits_q <= hits_q + 3'h1;
      end else begin
        locked_q <= 1'b1;
      end
    end else begin
      hits_q <= 3'h0;
    end
  end

  property p_tap_step;
    @(posedge sys_clk) disable iff (!rstn || !run)
      (phase_late && !phase_early && tap_q != 7'h7f) |=> (tap_q == $past(tap_q) + 7'h01);
  endproperty
  a_tap_step: assert property (p_tap_step) else $error("tap did not advance");
endmodule // dhc_tap_tracker

// ### dhc_dll_hold_cfg.sv
// dll mode, tap report and host bus hold delay configuration behind an apb slave
//
// Behaviour
// - straps latched within 25 cycles after release
// - dll mode from 0x76 bit2, 0x72 bit7
// - delay line has 128 taps, max widens
// - locked tap reported in 0xe3 bits 6:0
// - inverted straps load hold delay bits 5:4
// - undriven pulled-up straps give hold 00
// - hold delay field stays software writable
// - memory clock is 1:1 or 2:1 of sync
`timescale 1ns/100ps
`include "dhc_consts.svh"
module dhc_dll_hold_cfg
  import dhc_pkg::*;
#(
  parameter int LATCH_CYCLES = `DHC_LATCH_CYCLES,
  parameter int TAPS         = `DHC_TAP_COUNT
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        core_hard_reset_n,
  input  wire logic        bridge_hard_reset_n,
  input  wire logic        machine_check_strap,
  input  wire logic        clock_enable_strap,
  input  wire logic        clk_ratio_strap,
  input  wire logic        phase_late,
  input  wire logic        phase_early,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [1:0]       dll_mode,
  output logic             dll_locked,
  output logic [1:0]       host_bus_hold_delay,
  output logic             mem_clk_double,
  output logic             straps_latched
);

  ////////////////////////////////////////////////////////////////////////////
  // boot sequencing after hard reset release

  dhc_boot_e   boot_q;
  logic [4:0]  latch_cnt_q;
  logic        both_rel;
  logic        ratio_q;
  logic        strap_load;

  assign both_rel = core_hard_reset_n && bridge_hard_reset_n;

  always_ff @(posedge sys_clk) begin
    if (!rstn || !both_rel) begin
      boot_q      <= DHC_ST_RESET;
      latch_cnt_q <= 5'h00;
    end else begin
      unique case (boot_q)
        DHC_ST_RESET: begin
          boot_q      <= DHC_ST_LATCH;
          latch_cnt_q <= 5'h00;
        end
        DHC_ST_LATCH: begin
          latch_cnt_q <= latch_cnt_q + 5'h01;
          if (latch_cnt_q == 5'(LATCH_CYCLES - 2)) begin
            boot_q <= DHC_ST_RUN;
          end
        end
        DHC_ST_RUN: begin
          boot_q <= DHC_ST_RUN;
        end
      endcase
    end
  end

  // straps captured once, at the first cycle of the latch window
  assign strap_load = (boot_q == DHC_ST_LATCH) && (latch_cnt_q == 5'h00);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ratio_q <= 1'b0;
    end else if (strap_load) begin
      ratio_q <= clk_ratio_strap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb register file

  logic [7:0]  pmcr_two_q;
  logic [7:0]  dll_delay_q;
  logic [6:0]  tap_pos;
  logic        locked;
  logic        wr_en;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `DHC_ADDR_PMCR_TWO) || (a == `DHC_ADDR_DLL_DELAY) ||
               (a == `DHC_ADDR_TAP_POS);
  endfunction

  assign wr_en = psel && penable && pwrite && pready && addr_hit(paddr) && pstrb[0];

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pmcr_two_q <= `DHC_RST_PMCR_TWO;
    end else if (strap_load) begin
      pmcr_two_q[`DHC_BIT_HOLD_HI] <= ~machine_check_strap;
      pmcr_two_q[`DHC_BIT_HOLD_LO] <= ~clock_enable_strap;
    end else if (wr_en && paddr == `DHC_ADDR_PMCR_TWO) begin
      pmcr_two_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dll_delay_q <= `DHC_RST_DLL_DELAY;
    end else if (wr_en && paddr == `DHC_ADDR_DLL_DELAY) begin
      dll_delay_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pslverr <= !addr_hit(paddr);
      unique case (paddr)
        `DHC_ADDR_PMCR_TWO:  prdata <= {24'h00_0000, pmcr_two_q};
        `DHC_ADDR_DLL_DELAY: prdata <= {24'h00_0000, dll_delay_q};
        `DHC_ADDR_TAP_POS:   prdata <= {25'h000_0000, tap_pos};
        default:             prdata <= 32'h0000_0000;
      endcase
    end else begin
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dll tap tracking and outputs

  dhc_tap_tracker #(
    .TAPS        (TAPS)
  ) u_tap (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .run         (boot_q == DHC_ST_RUN),
    .phase_late  (phase_late),
    .phase_early (phase_early),
    .tap_q       (tap_pos),
    .locked_q    (locked)
  );

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dll_mode            <= DHC_MODE_NORM_NOEXT;
      dll_locked          <= 1'b0;
      host_bus_hold_delay <= 2'b00;
      mem_clk_double      <= 1'b0;
      straps_latched      <= 1'b0;
    end else begin
      dll_mode <= {dll_delay_q[`DHC_BIT_MAX_DELAY], pmcr_two_q[`DHC_BIT_DLL_EXTEND]};
      dll_locked          <= locked;
      host_bus_hold_delay <= pmcr_two_q[`DHC_BIT_HOLD_HI:`DHC_BIT_HOLD_LO];
      mem_clk_double      <= ratio_q;
      straps_latched      <= boot_q == DHC_ST_RUN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_strap_invert;
    @(posedge sys_clk) disable iff (!rstn)
      strap_load |=> pmcr_two_q[5:4] == ~{$past(machine_check_strap), $past(clock_enable_strap)};
  endproperty
  a_strap_invert: assert property (p_strap_invert) else $error("hold not inverted strap");

  property p_pullup_default;
    @(posedge sys_clk) disable iff (!rstn)
      (strap_load && machine_check_strap && clock_enable_strap) |=> pmcr_two_q[5:4] == 2'b00;
  endproperty
  a_pullup_default: assert property (p_pullup_default) else $error("hold default not 00");

  property p_latch_window;
    @(posedge sys_clk) disable iff (!rstn || !both_rel)
      (rstn && both_rel && boot_q == DHC_ST_RESET) |=> (boot_q == DHC_ST_LATCH) [*8];
  endproperty
  a_latch_window: assert property (p_latch_window) else $error("latch window short");

  property p_run_in_time;
    @(posedge sys_clk) disable iff (!rstn || !both_rel)
      (rstn && both_rel && boot_q == DHC_ST_RESET) |-> ##[1:25] (boot_q == DHC_ST_RUN);
  endproperty
  a_run_in_time: assert property (p_run_in_time) else $error("straps not latched in 25");

  property p_mode_follow;
    @(posedge sys_clk) disable iff (!rstn)
      ##1 dll_mode == {$past(dll_delay_q[2]), $past(pmcr_two_q[7])};
  endproperty
  a_mode_follow: assert property (p_mode_follow) else $error("dll mode mismatch");

  property p_hold_write;
    @(posedge sys_clk) disable iff (!rstn)
      (wr_en && paddr == `DHC_ADDR_PMCR_TWO && !strap_load) |->
        ##2 host_bus_hold_delay == $past(pwdata[5:4], 2);
  endproperty
  a_hold_write: assert property (p_hold_write) else $error("hold write lost");

  property p_tap_ro;
    @(posedge sys_clk) disable iff (!rstn)
      (psel && penable && !pready && paddr == `DHC_ADDR_TAP_POS) |=> prdata[31:7] == 25'h0;
  endproperty
  a_tap_ro: assert property (p_tap_ro) else $error("tap high bits not zero");

  property p_ratio;
    @(posedge sys_clk) disable iff (!rstn)
      strap_load |-> ##2 mem_clk_double == $past(clk_ratio_strap, 2);
  endproperty
  a_ratio: assert property (p_ratio) else $error("clock ratio not latched");

  property p_ready_pulse;
    @(posedge sys_clk) disable iff (!rstn)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");

  property p_tap_wr_ign;
    @(posedge sys_clk) disable iff (!rstn)
      (wr_en && paddr == `DHC_ADDR_TAP_POS && !strap_load) |=>
        $stable(pmcr_two_q) && $stable(dll_delay_q);
  endproperty
  a_tap_wr_ign: assert property (p_tap_wr_ign) else $error("tap write landed");

  property p_unmapped;
    @(posedge sys_clk) disable iff (!rstn)
      (psel && penable && !pready && !addr_hit(paddr)) |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_one_wait;
    @(posedge sys_clk) disable iff (!rstn)
      (psel && penable && !pready) |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready late");

  property p_hold_follow;
    @(posedge sys_clk) disable iff (!rstn)
      ##1 host_bus_hold_delay == $past(pmcr_two_q[`DHC_BIT_HOLD_HI:`DHC_BIT_HOLD_LO]);
  endproperty
  a_hold_follow: assert property (p_hold_follow) else $error("hold output stale");

  property p_clk_follow;
    @(posedge sys_clk) disable iff (!rstn)
      ##1 mem_clk_double == $past(ratio_q);
  endproperty
  a_clk_follow: assert property (p_clk_follow) else $error("clock ratio output stale");

  property p_ratio_hold;
    @(posedge sys_clk) disable iff (!rstn)
      !strap_load |=> $stable(ratio_q);
  endproperty
  a_ratio_hold: assert property (p_ratio_hold) else $error("clock ratio moved");

  property p_pmcr_stable;
    @(posedge sys_clk) disable iff (!rstn)
      !(strap_load || (wr_en && paddr == `DHC_ADDR_PMCR_TWO)) |=>
        $stable(pmcr_two_q);
  endproperty
  a_pmcr_stable: assert property (p_pmcr_stable) else $error("pmcr two moved");

  property p_delay_stable;
    @(posedge sys_clk) disable iff (!rstn)
      !(wr_en && paddr == `DHC_ADDR_DLL_DELAY) |=> $stable(dll_delay_q);
  endproperty
  a_delay_stable: assert property (p_delay_stable) else $error("dll delay moved");

  property p_latched_drop;
    @(posedge sys_clk) disable iff (!rstn)
      !both_rel |-> ##2 !straps_latched;
  endproperty
  a_latched_drop: assert property (p_latched_drop) else $error("latched during reset");

  property p_tap_report;
    @(posedge sys_clk) disable iff (!rstn)
      (psel && penable && !pready && paddr == `DHC_ADDR_TAP_POS) |=>
        prdata[6:0] == $past(tap_pos);
  endproperty
  a_tap_report: assert property (p_tap_report) else $error("tap read wrong");

  property p_pmcr_read;
    @(posedge sys_clk) disable iff (!rstn)
      (psel && penable && !pready && paddr == `DHC_ADDR_PMCR_TWO) |=>
        prdata == {24'h00_0000, $past(pmcr_two_q)};
  endproperty
  a_pmcr_read: assert property (p_pmcr_read) else $error("pmcr two read wrong");

endmodule // dhc_dll_hold_cfg

// ### dhc_dll_hold_cfg_test.sv
// self-checking bench for the dll mode, tap report and hold delay block
`timescale 1ns/100ps
`include "dhc_consts.svh"
module dhc_dll_hold_cfg_test;
  import dhc_pkg::*;
  logic        sys_clk             = 1'b0;
  logic        rstn                = 1'b0;
  logic        core_hard_reset_n   = 1'b0;
  logic        bridge_hard_reset_n = 1'b0;
  logic        machine_check_strap = 1'b1;
  logic        clock_enable_strap  = 1'b1;
  logic        clk_ratio_strap     = 1'b0;
  logic        phase_late          = 1'b0;
  logic        phase_early         = 1'b0;
  logic        psel                = 1'b0;
  logic        penable             = 1'b0;
  logic        pwrite              = 1'b0;
  logic [11:0] paddr               = 12'h000;
  logic [31:0] pwdata              = 32'h0;
  logic [3:0]  pstrb               = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  dll_mode;
  logic        dll_locked;
  logic [1:0]  host_bus_hold_delay;
  logic        mem_clk_double;
  logic        straps_latched;
  logic [31:0] rd;
  logic        err;
  int          seed                = 56;
  int          mismatches          = 0;
  int          tests_run           = 0;
  int          cyc                 = 0;

  dhc_dll_hold_cfg u_dhc_dll_hold_cfg (.sys_clk(sys_clk), .rstn(rstn),
    .core_hard_reset_n(core_hard_reset_n), .bridge_hard_reset_n(bridge_hard_reset_n),
    .machine_check_strap(machine_check_strap), .clock_enable_strap(clock_enable_strap),
    .clk_ratio_strap(clk_ratio_strap), .phase_late(phase_late), .phase_early(phase_early),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dll_mode(dll_mode), .dll_locked(dll_locked), .host_bus_hold_delay(host_bus_hold_delay),
    .mem_clk_double(mem_clk_double), .straps_latched(straps_latched));

  ////////////////////////////////////////////////////////////////////////////////
  always #50 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 3000) begin
      mismatches++;
      close_out();
    end
  end

  task close_out;
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function logic [1:0] exp_hold(input logic ms, input logic ce);
    return ~{ms, ce};
  endfunction

  // entered just after an edge; one idle edge follows each transfer
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= wr ? s : 4'h0;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // straps flip right after the latch window so a late sample shows up
  task boot(input logic ms, input logic ce, input logic ratio);
    core_hard_reset_n   <= 1'b0;
    bridge_hard_reset_n <= 1'b0;
    machine_check_strap <= ms;
    clock_enable_strap  <= ce;
    clk_ratio_strap     <= ratio;
    repeat (3) @(posedge sys_clk);
    core_hard_reset_n   <= 1'b1;
    bridge_hard_reset_n <= 1'b1;
    repeat (`DHC_LATCH_CYCLES) @(posedge sys_clk);
    chk("locked in latch", {31'h0, dll_locked}, 32'h0);
    machine_check_strap <= ~ms;
    clock_enable_strap  <= ~ce;
    clk_ratio_strap     <= ~ratio;
    while (straps_latched !== 1'b1) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
    chk("hold delay", {30'h0, host_bus_hold_delay}, {30'h0, exp_hold(ms, ce)});
    chk("mem clock double", {31'h0, mem_clk_double}, {31'h0, ratio});
    apb(1'b0, `DHC_ADDR_PMCR_TWO, $random(seed), 4'hf);
    chk("pmcr hold bits", {30'h0, rd[5:4]}, {30'h0, exp_hold(ms, ce)});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int          i;
    int          n;
    int          m;
    logic [1:0]  h;
    logic [31:0] d;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    boot(1'b1, 1'b1, 1'b0);
    for (i = 0; i < 4; i++) boot(i[1], i[0], (i == 3) || 1'($random(seed)));
    apb(1'b0, `DHC_ADDR_TAP_POS, $random(seed), 4'hf);
    chk("tap at start", rd, {25'h0, `DHC_TAP_START});
    n = ($random(seed) & 15) + 1;
    m = ($random(seed) & 7) + 1;
    phase_late <= 1'b1;
    repeat (n) @(posedge sys_clk);
    phase_late  <= 1'b0;
    phase_early <= 1'b1;
    repeat (m) @(posedge sys_clk);
    phase_early <= 1'b0;
    repeat (7) @(posedge sys_clk);
    chk("locked", {31'h0, dll_locked}, 32'h1);
    apb(1'b1, `DHC_ADDR_TAP_POS, 32'hff, 4'hf);
    apb(1'b0, `DHC_ADDR_TAP_POS, $random(seed), 4'hf);
    chk("tap value", rd, {25'h0, 7'(`DHC_TAP_START + n - m)});
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      d[2] = i[1];
      apb(1'b1, `DHC_ADDR_DLL_DELAY, d, 4'hf);
      h = 2'(3 - i);
      apb(1'b1, `DHC_ADDR_PMCR_TWO, {24'h0, i[0], 1'b0, h, 4'h5}, 4'hf);
      @(posedge sys_clk);
      chk("dll mode", {30'h0, dll_mode}, 32'(i));
      chk("hold out", {30'h0, host_bus_hold_delay}, {30'h0, h});
      apb(1'b0, `DHC_ADDR_PMCR_TWO, $random(seed), 4'hf);
      chk("pmcr read", rd, {24'h0, i[0], 1'b0, h, 4'h5});
      apb(1'b0, `DHC_ADDR_DLL_DELAY, $random(seed), 4'hf);
      chk("delay read", rd, {24'h0, d[7:0]});
    end
    apb(1'b1, `DHC_ADDR_PMCR_TWO, 32'h30, 4'he);
    @(posedge sys_clk);
    chk("no strobe write", {30'h0, host_bus_hold_delay}, 32'h0);
    apb(1'b0, 12'h100, $random(seed), 4'hf);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    close_out();
  end
endmodule // dhc_dll_hold_cfg_test
